//--- bench/buffered_async_serial_port_tb.sv
// Purpose: self-checking bench for the buffered serial port
// Assumes: 10 MHz clock, hard port at divisor 8 unless soft
// Notes: far side is remote_terminal; controls are one-cycle pulses
`timescale 1ns/10ps
module buffered_async_serial_port_tb;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic open_i, close_i, console_open_i, console_close_i, restart_i;
  logic soft_kind_i, flow_en_i, wr_valid_i, video_valid_i, rd_valid_i;
  logic [15:0] baud_div_i;
  logic [3:0] rx_level_i, rx_count_o, tx_space_o;
  logic [7:0] wr_data_i, video_data_i, rd_data_o, key_data_o;
  logic wr_ready_o, rd_ack_o, rd_got_o, key_valid_o, is_open_o;
  logic is_console_o, rx_empty_o, rx_level_o, rate_unreliable_o;
  logic pin_lock_o, rx_pin, cts_pin, tx_pin_o, tx_oe_o, rts_pin_o, rts_oe_o;
  logic [7:0] keys [$];
  int n_errors = 0;
  int compares = 0;
  int acc;
  always #50 clock_i = !clock_i;
  serial_port DUT (.clock_i(clock_i), .reset_i(reset_i), .open_i(open_i),
    .close_i(close_i), .console_open_i(console_open_i),
    .console_close_i(console_close_i), .restart_i(restart_i),
    .soft_kind_i(soft_kind_i), .flow_en_i(flow_en_i),
    .baud_div_i(baud_div_i), .rx_level_i(rx_level_i),
    .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
    .wr_data_i(wr_data_i), .video_valid_i(video_valid_i),
    .video_data_i(video_data_i), .rd_valid_i(rd_valid_i),
    .rd_ack_o(rd_ack_o), .rd_got_o(rd_got_o), .rd_data_o(rd_data_o),
    .key_valid_o(key_valid_o), .key_data_o(key_data_o),
    .is_open_o(is_open_o), .is_console_o(is_console_o),
    .rx_count_o(rx_count_o), .rx_empty_o(rx_empty_o),
    .tx_space_o(tx_space_o), .rx_level_o(rx_level_o),
    .rate_unreliable_o(rate_unreliable_o), .pin_lock_o(pin_lock_o),
    .rx_pin_i(rx_pin), .cts_pin_i(cts_pin), .tx_pin_o(tx_pin_o),
    .tx_oe_o(tx_oe_o), .rts_pin_o(rts_pin_o), .rts_oe_o(rts_oe_o));
  // undriven lines float high through pull-ups
  remote_terminal far (.clock_i(clock_i),
    .tx_line_i(tx_oe_o ? tx_pin_o : 1'b1),
    .rts_i(rts_oe_o ? rts_pin_o : 1'b1), .rx_line_o(rx_pin),
    .cts_o(cts_pin));
  always @(negedge clock_i) if (key_valid_o === 1'b1) keys.push_back(key_data_o);
  task automatic end_sim;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic hang(input string n);
    n_errors++;
    $display("Error %s expected done seen timeout", n);
    end_sim;
  endtask
  task automatic ctl(input logic [4:0] m);
    @(posedge clock_i);
    {open_i, close_i, console_open_i, console_close_i, restart_i} <= m;
    @(posedge clock_i);
    {open_i, close_i, console_open_i, console_close_i, restart_i} <= 5'h00;
    repeat (2) @(negedge clock_i);
  endtask
  task automatic wr(input logic [7:0] d);
    int k;
    for (k = 0; k < 20; k++) begin
      @(negedge clock_i);
      if (wr_ready_o === 1'b1) break;
    end
    if (k == 20) hang("wr_ready_o");
    @(posedge clock_i);
    wr_valid_i <= 1'b1;
    wr_data_i <= d;
    @(posedge clock_i);
    wr_valid_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic g, input logic [7:0] d);
    int k;
    @(posedge clock_i);
    rd_valid_i <= 1'b1;
    @(posedge clock_i);
    rd_valid_i <= 1'b0;
    for (k = 0; k < 3; k++) begin
      @(negedge clock_i);
      if (rd_ack_o === 1'b1) break;
    end
    if (k == 3) hang("rd_ack_o");
    chk("rd_got_o", 16'(g), 16'(rd_got_o));
    if (g) chk("rd_data_o", 16'(d), 16'(rd_data_o));
  endtask
  task automatic wait_heard(input int n);
    int k;
    for (k = 0; k < 20000 && far.heard.size() < n; k++) @(negedge clock_i);
    if (k == 20000) hang("heard");
  endtask
  task automatic cts_hold(input logic h);
    @(posedge clock_i);
    far.hold_off <= h;
  endtask
  initial begin
    {open_i, close_i, console_open_i, console_close_i, restart_i} = 5'h00;
    {soft_kind_i, wr_valid_i, video_valid_i, rd_valid_i} = 4'h0;
    flow_en_i = 1'b1;
    baud_div_i = 16'h0008;
    rx_level_i = 4'h6;
    wr_data_i = 8'h00;
    video_data_i = 8'h00;
    repeat (6) @(posedge clock_i);
    reset_i <= 1'b0;
    @(negedge clock_i);
    chk("tx_pin_o", 16'h0001, 16'(tx_pin_o));
    chk("rx_empty_o", 16'h0001, 16'(rx_empty_o));
    chk("tx_space_o", 16'h0008, 16'(tx_space_o));
    ctl(5'h10);
    chk("open", 16'h0007, 16'({is_open_o, tx_oe_o, pin_lock_o}));
    chk("rts", 16'h0003, 16'({rts_oe_o, rts_pin_o}));
    chk("rate_unreliable_o", 16'h0001, 16'(rate_unreliable_o));
    rd(1'b0, 8'h00);
    wr(8'h5a);
    wr(8'h01);
    wr(8'h80);
    wait_heard(3);
    chk("heard0", 16'h005a, 16'(far.heard[0]));
    chk("heard1", 16'h0001, 16'(far.heard[1]));
    chk("heard2", 16'h0080, 16'(far.heard[2]));
    for (int i = 0; i < 10; i++) far.send_char(8'h30 + 8'(i));
    repeat (30) @(negedge clock_i);
    chk("rx_count_o", 16'h0008, 16'(rx_count_o));
    chk("rx_empty_o", 16'h0000, 16'(rx_empty_o));
    chk("rx_level_o", 16'h0001, 16'(rx_level_o));
    for (int i = 0; i < 8; i++) begin
      rd(1'b1, 8'h32 + 8'(i));
      @(negedge clock_i);
      chk("rx_count_o", 16'(7 - i), 16'(rx_count_o));
      if (i == 1) chk("rx_level_o", 16'h0001, 16'(rx_level_o));
      if (i == 2) chk("rx_level_o", 16'h0000, 16'(rx_level_o));
    end
    chk("rx_empty_o", 16'h0001, 16'(rx_empty_o));
    cts_hold(1'b1);
    acc = 0;
    for (int k = 0; k < 12; k++) begin
      @(negedge clock_i);
      if (wr_ready_o === 1'b1) begin
        wr(8'hc0 + 8'(acc));
        acc++;
      end
    end
    chk("accepted", 16'h0008, 16'(acc));
    chk("tx_space_o", 16'h0000, 16'(tx_space_o));
    chk("wr_ready_o", 16'h0000, 16'(wr_ready_o));
    chk("held", 16'h0003, 16'(far.heard.size()));
    cts_hold(1'b0);
    wait_heard(11);
    for (int i = 0; i < 8; i++)
      chk("heard", 16'h00c0 + 16'(i), 16'(far.heard[3 + i]));
    repeat (4) @(negedge clock_i);
    chk("tx_space_o", 16'h0008, 16'(tx_space_o));
    far.send_char(8'h77);
    cts_hold(1'b1);
    wr(8'h11);
    repeat (30) @(negedge clock_i);
    chk("rx_count_o", 16'h0001, 16'(rx_count_o));
    ctl(5'h08);
    chk("rx_count_o", 16'h0000, 16'(rx_count_o));
    chk("tx_space_o", 16'h0008, 16'(tx_space_o));
    chk("closed", 16'h0000,
      16'({is_open_o, tx_oe_o, rts_oe_o, pin_lock_o}));
    cts_hold(1'b0);
    repeat (200) @(negedge clock_i);
    chk("flushed", 16'h000b, 16'(far.heard.size()));
    soft_kind_i <= 1'b1;
    ctl(5'h10);
    chk("rate_unreliable_o", 16'h0000, 16'(rate_unreliable_o));
    far.div = 521;
    wr(8'h3c);
    wait_heard(12);
    chk("soft char", 16'h003c, 16'(far.heard[11]));
    ctl(5'h08);
    soft_kind_i <= 1'b0;
    far.div = 8;
    ctl(5'h04);
    chk("console", 16'h0003, 16'({is_console_o, is_open_o}));
    far.send_char(8'h41);
    for (int k = 0; k < 200 && keys.size() == 0; k++) @(negedge clock_i);
    if (keys.size() == 0) hang("key_valid_o");
    chk("key_data_o", 16'h0041, 16'(keys[0]));
    @(posedge clock_i);
    video_valid_i <= 1'b1;
    video_data_i <= 8'h42;
    @(posedge clock_i);
    video_valid_i <= 1'b0;
    wait_heard(13);
    chk("echo", 16'h0042, 16'(far.heard[12]));
    ctl(5'h01);
    chk("is_console_o", 16'h0001, 16'(is_console_o));
    ctl(5'h08);
    chk("is_open_o", 16'h0001, 16'(is_open_o));
    ctl(5'h02);
    chk("console shut", 16'h0000, 16'({is_console_o, is_open_o}));
    end_sim;
  end
endmodule

//--- bench/remote_terminal.sv
// Purpose: far-side serial terminal model, 8N1 both ways
// Assumes: bit time is div clock cycles, set by the bench
// Notes: framed chars heard on the tx line land in heard
`timescale 1ns/10ps
module remote_terminal (
  // clock
  input wire logic clock_i,
  // lines
  input wire logic tx_line_i,
  input wire logic rts_i,
  output logic rx_line_o,
  output logic cts_o
);
  int div = 8;
  logic hold_off = 1'b0;
  logic [7:0] heard [$];
  logic [7:0] b;
  initial rx_line_o = 1'b1; // idle high
  assign cts_o = !hold_off; // low asks the port to stop
  task automatic send_char(input logic [7:0] d);
    // hold off while the port says stop
    for (int k = 0; k < 1000 && rts_i !== 1'b1; k++) @(posedge clock_i);
    @(posedge clock_i) rx_line_o <= 1'b0; // start bit low
    repeat (div - 1) @(posedge clock_i);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_i) rx_line_o <= d[i]; // lsb first
      repeat (div - 1) @(posedge clock_i);
    end
    @(posedge clock_i) rx_line_o <= 1'b1; // one stop bit
    repeat (div - 1) @(posedge clock_i);
  endtask
  // mid-bit sampling; a bad stop bit drops the char
  always begin
    @(posedge clock_i);
    if (tx_line_i === 1'b0) begin
      repeat (div / 2) @(posedge clock_i);
      for (int i = 0; i < 8; i++) begin
        repeat (div) @(posedge clock_i);
        b[i] = tx_line_i;
      end
      repeat (div) @(posedge clock_i);
      if (tx_line_i === 1'b1) heard.push_back(b);
    end
  end
endmodule

//--- logic/serial_port.sv
// Purpose: buffered async serial port, 8N1, optional rts/cts
// Assumes: single 10 MHz clock, synchronous active-high reset
// Notes: rx and tx buffers are 8-entry fifos
// Notes on behaviour
// RULE_01 - line idles high, low start bit, data high for one, stop high.
// RULE_02 - handshake low means stop sending, high means ok to send.
// RULE_03 - the software-timed port kind is limited to 19200 bps.
// RULE_04 - hardware ports accept up to 8 Mbps, above 115200 flagged; the flag needs a divisor below 86, so 116279 bps at divisor 86 is unflagged.
// RULE_05 - a char arriving into a full rx buffer drops the oldest one.
// RULE_06 - a write into a full tx buffer stalls the writer.
// RULE_07 - the count of waiting received chars is reported.
// RULE_08 - empty is high exactly when the rx buffer holds nothing.
// RULE_09 - free tx space in chars is reported.
// RULE_10 - reads return only what is buffered and never wait; in console mode a read gets no rd_ack_o.
// RULE_11 - opening drives pin directions and locks general pin use.
// RULE_12 - closing flushes both buffers and releases the pins.
// RULE_13 - a level flag rises when rx fill reaches the set level.
// RULE_14 - console mode feeds rx as keystrokes and echoes video out.
// RULE_15 - console stays open until its own close, ignoring restarts.
// RULE_16 - 8 data bits lsb first, no parity, one stop, baud-timed.
`timescale 1ns/10ps
module serial_port #(
  parameter int DEPTH = serial_port_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // control
  input wire logic open_i,
  input wire logic close_i,
  input wire logic console_open_i,
  input wire logic console_close_i,
  input wire logic restart_i,
  input wire logic soft_kind_i,
  input wire logic flow_en_i,
  input wire logic [15:0] baud_div_i,
  input wire logic [3:0] rx_level_i,
  // write side
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [7:0] wr_data_i,
  input wire logic video_valid_i,
  input wire logic [7:0] video_data_i,
  // read side
  input wire logic rd_valid_i,
  output logic rd_ack_o,
  output logic rd_got_o,
  output logic [7:0] rd_data_o,
  output logic key_valid_o,
  output logic [7:0] key_data_o,
  // status
  output logic is_open_o,
  output logic is_console_o,
  output logic [3:0] rx_count_o,
  output logic rx_empty_o,
  output logic [3:0] tx_space_o,
  output logic rx_level_o,
  output logic rate_unreliable_o,
  output logic pin_lock_o,
  // pins
  input wire logic rx_pin_i,
  input wire logic cts_pin_i,
  output logic tx_pin_o,
  output logic tx_oe_o,
  output logic rts_pin_o,
  output logic rts_oe_o
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_START = 2'b01, ST_DATA = 2'b11, ST_STOP = 2'b10
  } bit_state_t;

  logic [1:0] rx_sync_reg, cts_sync_reg;
  logic open_reg, open_next, cons_reg, cons_next;
  logic [15:0] div_reg, div_next;
  logic active, flush;
  logic [3:0] txc, rxc;
  logic tx_in_valid, tx_in_ready, tx_out_valid, tx_pop;
  logic [7:0] tx_in_data, tx_out_data;
  logic rx_push, rx_out_valid, rx_pop, rx_drop;
  logic [7:0] rx_out_data;

  // pin inputs double flopped
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rx_sync_reg <= serial_port_pkg::IDLE_LEVEL;
      cts_sync_reg <= serial_port_pkg::IDLE_LEVEL;
    end else begin
      rx_sync_reg <= {rx_sync_reg[0], rx_pin_i};
      cts_sync_reg <= {cts_sync_reg[0], cts_pin_i};
    end
  end

  // open/console control
  always_comb begin
    open_next = open_reg;
    cons_next = cons_reg;
    div_next = div_reg;
    if (console_open_i) begin
      cons_next = 1'b1;
    end else if (console_close_i) begin
      cons_next = 1'b0; // [RULE_15]
    end
    if (open_i || console_open_i) begin
      open_next = 1'b1;
      div_next = baud_div_i;
      if (soft_kind_i && baud_div_i < serial_port_pkg::SOFT_MIN_DIV) begin
        div_next = serial_port_pkg::SOFT_MIN_DIV; // [RULE_03]
      end else if (baud_div_i < serial_port_pkg::HARD_MIN_DIV) begin
        div_next = serial_port_pkg::HARD_MIN_DIV; // [RULE_04]
      end
    end else if ((close_i || restart_i) && !cons_reg) begin
      open_next = 1'b0; // [RULE_15]
    end else if (console_close_i) begin
      open_next = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      open_reg <= 1'b0;
      cons_reg <= 1'b0;
      div_reg <= serial_port_pkg::DIV_RESET;
    end else begin
      open_reg <= open_next;
      cons_reg <= cons_next;
      div_reg <= div_next;
    end
  end

  assign active = open_reg;
  assign flush = open_reg && !open_next; // [RULE_12]

  // tx buffer: writes, or video echo in console mode
  assign tx_in_valid = active && (cons_reg ? video_valid_i : wr_valid_i);
  assign tx_in_data = cons_reg ? video_data_i : wr_data_i; // [RULE_14]

  sync_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(3)) u_tx_fifo (
    .clock_i(clock_i), .reset_i(reset_i), .flush_i(flush),
    .in_valid_i(tx_in_valid), .in_ready_o(tx_in_ready),
    .in_data_i(tx_in_data),
    .out_valid_o(tx_out_valid), .out_ready_i(tx_pop),
    .out_data_o(tx_out_data), .count_o(txc)
  );

  // transmitter
  bit_state_t ts_reg, ts_next;
  logic [15:0] tcnt_reg, tcnt_next;
  logic [2:0] tbit_reg, tbit_next;
  logic [7:0] tsh_reg, tsh_next;
  logic tx_reg, tx_next;
  logic cts_ok;

  assign cts_ok = !flow_en_i || cts_sync_reg[1]; // [RULE_02]
  assign tx_pop = (ts_reg == ST_IDLE) && tx_out_valid && cts_ok && active;

  always_comb begin
    ts_next = ts_reg;
    tcnt_next = tcnt_reg;
    tbit_next = tbit_reg;
    tsh_next = tsh_reg;
    tx_next = tx_reg;
    if (tcnt_reg != '0) begin
      tcnt_next = tcnt_reg - 16'h0001;
    end
    case (ts_reg)
      ST_IDLE: begin
        tx_next = 1'b1; // [RULE_01]
        if (tx_pop) begin
          tsh_next = tx_out_data;
          tx_next = 1'b0; // [RULE_01]
          tcnt_next = div_reg - 16'h0001;
          ts_next = ST_START;
        end
      end
      ST_START: begin
        if (tcnt_reg == '0) begin
          tx_next = tsh_reg[0]; // [RULE_16]
          tsh_next = {1'b1, tsh_reg[7:1]};
          tbit_next = '0;
          tcnt_next = div_reg - 16'h0001;
          ts_next = ST_DATA;
        end
      end
      ST_DATA: begin
        if (tcnt_reg == '0) begin
          tcnt_next = div_reg - 16'h0001;
          if (tbit_reg == 3'h7) begin
            tx_next = 1'b1; // [RULE_01]
            ts_next = ST_STOP;
          end else begin
            tx_next = tsh_reg[0];
            tsh_next = {1'b1, tsh_reg[7:1]};
            tbit_next = tbit_reg + 3'h1;
          end
        end
      end
      ST_STOP: begin
        if (tcnt_reg == '0) begin
          ts_next = ST_IDLE;
        end
      end
      default: ts_next = ST_IDLE;
    endcase
    if (!active) begin
      ts_next = ST_IDLE;
      tx_next = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ts_reg <= ST_IDLE;
      tcnt_reg <= '0;
      tbit_reg <= '0;
      tsh_reg <= '0;
      tx_reg <= 1'b1;
    end else begin
      ts_reg <= ts_next;
      tcnt_reg <= tcnt_next;
      tbit_reg <= tbit_next;
      tsh_reg <= tsh_next;
      tx_reg <= tx_next;
    end
  end

  // receiver
  bit_state_t rs_reg, rs_next;
  logic [15:0] rcnt_reg, rcnt_next;
  logic [2:0] rbit_reg, rbit_next;
  logic [7:0] rsh_reg, rsh_next;
  logic done_reg, done_next;
  logic rxd;

  assign rxd = rx_sync_reg[1];

  always_comb begin
    rs_next = rs_reg;
    rcnt_next = rcnt_reg;
    rbit_next = rbit_reg;
    rsh_next = rsh_reg;
    done_next = 1'b0;
    if (rcnt_reg != '0) begin
      rcnt_next = rcnt_reg - 16'h0001;
    end
    case (rs_reg)
      ST_IDLE: begin
        if (!rxd) begin
          rcnt_next = {1'b0, div_reg[15:1]}; // sample mid-bit
          rs_next = ST_START;
        end
      end
      ST_START: begin
        if (rcnt_reg == '0) begin
          rcnt_next = div_reg - 16'h0001;
          rbit_next = '0;
          rs_next = rxd ? ST_IDLE : ST_DATA; // glitch rejected
        end
      end
      ST_DATA: begin
        if (rcnt_reg == '0) begin
          rcnt_next = div_reg - 16'h0001;
          rsh_next = {rxd, rsh_reg[7:1]}; // [RULE_16]
          rbit_next = rbit_reg + 3'h1;
          if (rbit_reg == 3'h7) begin
            rs_next = ST_STOP;
          end
        end
      end
      ST_STOP: begin
        if (rcnt_reg == '0) begin
          done_next = rxd; // framing error drops the char [RULE_01]
          rs_next = ST_IDLE;
        end
      end
      default: rs_next = ST_IDLE;
    endcase
    if (!active) begin
      rs_next = ST_IDLE;
      done_next = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rs_reg <= ST_IDLE;
      rcnt_reg <= '0;
      rbit_reg <= '0;
      rsh_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      rs_reg <= rs_next;
      rcnt_reg <= rcnt_next;
      rbit_reg <= rbit_next;
      rsh_reg <= rsh_next;
      done_reg <= done_next;
    end
  end

  // rx buffer, full drops oldest
  logic rx_in_ready;
  logic rd_take;
  assign rx_push = done_reg;
  assign rx_drop = rx_push && (rxc == 4'(DEPTH)); // [RULE_05]
  assign rd_take = (cons_reg || rd_valid_i) && rx_out_valid;
  assign rx_pop = rx_drop || rd_take;

  sync_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(3)) u_rx_fifo (
    .clock_i(clock_i), .reset_i(reset_i), .flush_i(flush),
    .in_valid_i(rx_push || 1'b0), .in_ready_o(rx_in_ready),
    .in_data_i(rsh_reg),
    .out_valid_o(rx_out_valid), .out_ready_i(rx_pop),
    .out_data_o(rx_out_data), .count_o(rxc)
  );

  // registered outputs
  logic [3:0] cnt_after;
  always_comb begin
    cnt_after = rxc + 4'(rx_push && !rx_drop) - 4'(rd_take && !rx_drop);
    if (flush) begin
      cnt_after = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rd_ack_o <= 1'b0;
      rd_got_o <= 1'b0;
      rd_data_o <= '0;
      key_valid_o <= 1'b0;
      key_data_o <= '0;
      rx_count_o <= '0;
      rx_empty_o <= 1'b1;
      tx_space_o <= 4'(DEPTH);
      rx_level_o <= 1'b0;
      rate_unreliable_o <= 1'b0;
      wr_ready_o <= 1'b0;
      tx_pin_o <= 1'b1;
      tx_oe_o <= 1'b0;
      rts_pin_o <= 1'b0;
      rts_oe_o <= 1'b0;
      pin_lock_o <= 1'b0;
      is_open_o <= 1'b0;
      is_console_o <= 1'b0;
    end else begin
      rd_ack_o <= rd_valid_i && !cons_reg; // acks next cycle, no ack in console mode [RULE_10]
      rd_got_o <= rd_valid_i && !cons_reg && rx_out_valid && !rx_drop;
      rd_data_o <= rx_out_data;
      key_valid_o <= cons_reg && rx_out_valid && !rx_drop; // [RULE_14]
      key_data_o <= rx_out_data;
      rx_count_o <= cnt_after; // [RULE_07]
      rx_empty_o <= (cnt_after == '0); // [RULE_08]
      tx_space_o <= flush ? 4'(DEPTH) : 4'(DEPTH) - txc
        - 4'(tx_in_valid && tx_in_ready) + 4'(tx_pop); // [RULE_09]
      rx_level_o <= active && rx_level_i != '0
        && cnt_after >= rx_level_i; // [RULE_13]
      rate_unreliable_o <= div_reg < serial_port_pkg::RELIABLE_DIV;
      wr_ready_o <= active && !cons_reg && tx_in_ready; // [RULE_06]
      tx_pin_o <= tx_next;
      tx_oe_o <= open_next; // [RULE_11]
      rts_pin_o <= open_next && flow_en_i; // [RULE_02]
      rts_oe_o <= open_next && flow_en_i; // [RULE_12]
      pin_lock_o <= open_next; // [RULE_11]
      is_open_o <= open_next;
      is_console_o <= cons_next;
    end
  end

  a_tx_idle_high: assert property (@(posedge clock_i) disable iff (reset_i)
    !tx_oe_o |-> tx_pin_o) else $error("tx not idle high"); // [RULE_01]
  a_cts_stop: assert property (@(posedge clock_i) disable iff (reset_i)
    flow_en_i && !cts_sync_reg[1] |-> !tx_pop)
    else $error("sent while cts low"); // [RULE_02]
  a_soft_limit: assert property (@(posedge clock_i) disable iff (reset_i)
    $rose(open_reg) && soft_kind_i && $past(open_i)
    |-> div_reg >= serial_port_pkg::SOFT_MIN_DIV)
    else $error("soft rate too high"); // [RULE_03]
  a_hard_limit: assert property (@(posedge clock_i) disable iff (reset_i)
    open_reg |-> div_reg >= serial_port_pkg::HARD_MIN_DIV)
    else $error("rate above max"); // [RULE_04]
  a_drop_oldest: assert property (@(posedge clock_i) disable iff (reset_i)
    rx_drop && !flush |=> rxc == 4'(DEPTH))
    else $error("full rx lost count"); // [RULE_05]
  a_rx_keep_new: assert property (@(posedge clock_i) disable iff (reset_i)
    rx_push |-> rx_in_ready) else $error("newest rx char lost"); // [RULE_05]
  a_empty_match: assert property (@(posedge clock_i) disable iff (reset_i)
    rx_empty_o == (rx_count_o == '0))
    else $error("empty mismatch"); // [RULE_08]
  a_read_nowait: assert property (@(posedge clock_i) disable iff (reset_i)
    rd_valid_i && !cons_reg |=> rd_ack_o)
    else $error("read waited"); // [RULE_10]
  a_close_flush: assert property (@(posedge clock_i) disable iff (reset_i)
    flush |=> rxc == '0 && txc == '0 ##1 !pin_lock_o)
    else $error("close left data"); // [RULE_12]
  a_console_hold: assert property (@(posedge clock_i) disable iff (reset_i)
    cons_reg && restart_i && !console_close_i |=> open_reg)
    else $error("console closed by restart"); // [RULE_15]
endmodule

//--- logic/serial_port_pkg.sv
// Purpose: shared constants for the buffered serial port
// Assumes: 10 MHz system clock, 8N1 framing
// Notes: baud divisor is clock cycles per bit
package serial_port_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SOFT_MAX_BAUD = 19_200;
  localparam int unsigned HARD_MAX_BAUD = 8_000_000;
  localparam int unsigned RELIABLE_BAUD = 115_200;
  localparam int unsigned DIV_W = 16;
  // least divisor per port kind, rounded up
  localparam logic [15:0] SOFT_MIN_DIV =
    16'((CLK_HZ + SOFT_MAX_BAUD - 1) / SOFT_MAX_BAUD);
  localparam logic [15:0] HARD_MIN_DIV =
    16'((CLK_HZ + HARD_MAX_BAUD - 1) / HARD_MAX_BAUD);
  localparam logic [15:0] RELIABLE_DIV = 16'(CLK_HZ / RELIABLE_BAUD);
  localparam logic [15:0] DIV_RESET = 16'h0411;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [3:0] LEVEL_RESET = 4'h6;
  localparam logic [1:0] IDLE_LEVEL = 2'h3;
endpackage

//--- logic/sync_fifo.sv
// Purpose: flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: flush empties in one cycle
`timescale 1ns/10ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // fill level
  output logic [AW:0] count_o
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] rd_reg, rd_next, wr_reg, wr_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  // a pop in the same cycle frees the slot for a push when full
  assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH)) || out_ready_i;
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rd_reg];
  assign count_o = cnt_reg;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    rd_next = rd_reg + AW'(pop);
    wr_next = wr_reg + AW'(push);
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i) begin
      rd_next = '0;
      wr_next = '0;
      cnt_next = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rd_reg <= '0;
      wr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (push && !flush_i) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end
endmodule
